// ===== wmc_cmd_port.sv
// Command and status port of the weighing transmitter
`timescale 1ns/1ps
`include "wmc_map.svh"
module wmc_cmd_port import wmc_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_err,
    input wire logic core_done,
    input wire logic core_ok,
    output logic zero_req,
    output logic tare_req,
    output logic preset_tare_req,
    output logic setpoint1_load,
    output logic setpoint2_load,
    output logic reboot_req,
    output logic [31:0] action_value,
    output logic dout1,
    output logic dout2,
    output logic cmd_busy
);
    wmc_if cif();

    wmc_regs u_regs (
        .clock(clock),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .reg_err(reg_err),
        .cif(cif.regs_mp)
    );

    wmc_state_t state_r, state_nxt;
    logic [7:0] code_r, code_nxt;
    logic [7:0] last_r, last_nxt;
    logic [1:0] res_r, res_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [31:0] val_r, val_nxt;
    logic zero_r, zero_nxt, tare_r, tare_nxt, ptare_r, ptare_nxt;
    logic sp1_r, sp1_nxt, sp2_r, sp2_nxt, boot_r, boot_nxt;
    logic dout1_r, dout1_nxt, dout2_r, dout2_nxt;
    logic fin;
    logic [7:0] fin_code;
    logic [1:0] fin_res;
    logic [15:0] cmd_stat;
    logic [15:0] out_stat;

    always_comb begin
        state_nxt = state_r;
        code_nxt = code_r;
        last_nxt = last_r;
        res_nxt = res_r;
        cnt_nxt = cnt_r;
        val_nxt = val_r;
        zero_nxt = 1'b0;
        tare_nxt = 1'b0;
        ptare_nxt = 1'b0;
        sp1_nxt = 1'b0;
        sp2_nxt = 1'b0;
        boot_nxt = 1'b0;
        dout1_nxt = dout1_r;
        dout2_nxt = dout2_r;
        fin = 1'b0;
        fin_code = code_r;
        fin_res = `WMC_RES_OK;
        unique case (state_r)
            WMC_ST_IDLE: begin
                if (cif.go) begin
                    code_nxt = cif.code[7:0];
                    fin_code = cif.code[7:0];
                    unique case (cif.code)
                        `WMC_CODE_ZERO: begin
                            zero_nxt = 1'b1;
                            state_nxt = WMC_ST_WAIT;
                        end
                        `WMC_CODE_TARE: begin
                            tare_nxt = 1'b1;
                            state_nxt = WMC_ST_WAIT;
                        end
                        `WMC_CODE_PTARE: begin
                            ptare_nxt = 1'b1;
                            val_nxt = cif.p1;
                            state_nxt = WMC_ST_WAIT;
                        end
                        `WMC_CODE_SP1: begin
                            sp1_nxt = 1'b1;
                            val_nxt = cif.p1;
                            state_nxt = WMC_ST_WAIT;
                        end
                        `WMC_CODE_SP2: begin
                            sp2_nxt = 1'b1;
                            val_nxt = cif.p1;
                            state_nxt = WMC_ST_WAIT;
                        end
                        `WMC_CODE_DOUT: begin
                            // Outputs are held here, so the command ends now
                            dout1_nxt = cif.p1[`WMC_DOUT1_BIT];
                            dout2_nxt = cif.p1[`WMC_DOUT2_BIT];
                            fin = 1'b1;
                        end
                        `WMC_CODE_REBOOT: begin
                            // No answer can come back from a restart
                            boot_nxt = 1'b1;
                            fin = 1'b1;
                        end
                        default: begin
                            fin = 1'b1;
                            fin_res = `WMC_RES_UNKNOWN;
                        end
                    endcase
                end
            end
            WMC_ST_WAIT: begin
                if (core_done) begin
                    fin = 1'b1;
                    fin_res = core_ok ? `WMC_RES_OK : `WMC_RES_FAIL;
                    state_nxt = WMC_ST_IDLE;
                end
            end
        endcase
        if (fin) begin
            last_nxt = fin_code;
            res_nxt = fin_res;
            cnt_nxt = cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_r <= WMC_ST_IDLE;
            code_r <= 8'h00;
            last_r <= 8'h00;
            res_r <= `WMC_RES_NONE;
            cnt_r <= 4'h0;
            val_r <= 32'h0000_0000;
            zero_r <= 1'b0;
            tare_r <= 1'b0;
            ptare_r <= 1'b0;
            sp1_r <= 1'b0;
            sp2_r <= 1'b0;
            boot_r <= 1'b0;
            dout1_r <= 1'b0;
            dout2_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            code_r <= code_nxt;
            last_r <= last_nxt;
            res_r <= res_nxt;
            cnt_r <= cnt_nxt;
            val_r <= val_nxt;
            zero_r <= zero_nxt;
            tare_r <= tare_nxt;
            ptare_r <= ptare_nxt;
            sp1_r <= sp1_nxt;
            sp2_r <= sp2_nxt;
            boot_r <= boot_nxt;
            dout1_r <= dout1_nxt;
            dout2_r <= dout2_nxt;
        end
    end

    always_comb begin
        cmd_stat = 16'h0000;
        cmd_stat[`WMC_LAST_MSB:`WMC_LAST_LSB] = last_r;
        cmd_stat[`WMC_RES_MSB:`WMC_RES_LSB] = res_r;
        cmd_stat[`WMC_CNT_MSB:`WMC_CNT_LSB] = cnt_r;
        out_stat = 16'h0000;
        out_stat[`WMC_DOUT1_BIT] = dout1_r;
        out_stat[`WMC_DOUT2_BIT] = dout2_r;
    end

    assign cif.busy = state_r != WMC_ST_IDLE;
    assign cif.cmd_stat = cmd_stat;
    assign cif.out_stat = out_stat;
    assign cmd_busy = state_r != WMC_ST_IDLE;
    assign zero_req = zero_r;
    assign tare_req = tare_r;
    assign preset_tare_req = ptare_r;
    assign setpoint1_load = sp1_r;
    assign setpoint2_load = sp2_r;
    assign reboot_req = boot_r;
    assign action_value = val_r;
    assign dout1 = dout1_r;
    assign dout2 = dout2_r;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_go(logic [15:0] c);
        cif.go && cif.code == c;
    endsequence

    a_zero_pulse: assert property (s_go(`WMC_CODE_ZERO) |=>
        zero_req && !tare_req ##1 !zero_req)
        else $error("Zero command gave no single pulse");
    a_tare_pulse: assert property (s_go(`WMC_CODE_TARE) |=>
        tare_req && !zero_req && cmd_busy)
        else $error("Tare command not issued");
    a_preset_value: assert property (s_go(`WMC_CODE_PTARE) |=>
        preset_tare_req && action_value == $past(cif.p1))
        else $error("Preset tare value not taken at code write");
    a_setpoint_load: assert property (s_go(`WMC_CODE_SP2) |=>
        setpoint2_load && !setpoint1_load && action_value == $past(cif.p1))
        else $error("Setpoint two not loaded");
    a_sp1_load: assert property (s_go(`WMC_CODE_SP1) |=>
        setpoint1_load && !setpoint2_load && action_value == $past(cif.p1))
        else $error("Setpoint one not loaded");
    a_dout_drive: assert property (s_go(`WMC_CODE_DOUT) |=>
        dout1 == $past(cif.p1[1]) && dout2 == $past(cif.p1[0]) && !cmd_busy)
        else $error("Digital outputs not driven from parameter");
    a_reboot_pulse: assert property (s_go(`WMC_CODE_REBOOT) |=>
        reboot_req ##1 !reboot_req)
        else $error("Restart request missing");
    a_count_step: assert property (cmd_busy && core_done |=>
        cnt_r == $past(cnt_r) + 4'h1 && !cmd_busy)
        else $error("Processed count did not advance");
    a_busy_hold: assert property (
        cmd_busy && !core_done |=> cmd_busy && cnt_r == $past(cnt_r))
        else $error("Count moved while a command was pending");
    a_last_result: assert property (
        cmd_busy && core_done && !core_ok |=>
        cmd_stat[15:8] == $past(code_r) && cmd_stat[5:4] == `WMC_RES_FAIL)
        else $error("Last command or result misreported");
    a_unknown_code: assert property (
        cif.go && !(cif.code inside {`WMC_CODE_ZERO, `WMC_CODE_TARE,
        `WMC_CODE_PTARE, `WMC_CODE_SP1, `WMC_CODE_SP2, `WMC_CODE_DOUT,
        `WMC_CODE_REBOOT}) |=> res_r == `WMC_RES_UNKNOWN &&
        last_r == $past(cif.code[7:0]) && !cmd_busy)
        else $error("Unknown code not reported");
    a_out_status: assert property (
        out_stat == {14'h0000, dout1, dout2})
        else $error("Output status bits wrong");

    c_tare_done: cover property (s_go(`WMC_CODE_TARE) ##[1:20] core_done);
    c_dout_set: cover property (s_go(`WMC_CODE_DOUT) ##1 dout1 && dout2);
    c_unknown: cover property (cif.go ##1 res_r == `WMC_RES_UNKNOWN);
    c_refused: cover property (cmd_busy && reg_wr &&
        reg_addr == `WMC_ADDR_CMD_CODE);
    c_fail: cover property (cmd_busy && core_done && !core_ok);
endmodule // wmc_cmd_port

// ===== wmc_map.svh
// Register numbers, field positions and command codes of the command port
`ifndef WMC_MAP_SVH
`define WMC_MAP_SVH

`define WMC_ADDR_CMD_STATUS 16'h7536
`define WMC_ADDR_OUT_STATUS 16'h7537
`define WMC_ADDR_CH1_UV 16'h759f
`define WMC_ADDR_CMD_CODE 16'h9c41
`define WMC_ADDR_P1_HIGH 16'h9c42
`define WMC_ADDR_P1_LOW 16'h9c43
`define WMC_ADDR_P2_HIGH 16'h9c44
`define WMC_ADDR_P2_LOW 16'h9c45

`define WMC_CODE_NONE 16'h0000
`define WMC_CODE_ZERO 16'h0001
`define WMC_CODE_TARE 16'h0002
`define WMC_CODE_PTARE 16'h0003
`define WMC_CODE_SP1 16'h000a
`define WMC_CODE_SP2 16'h000b
`define WMC_CODE_DOUT 16'h0019
`define WMC_CODE_REBOOT 16'h0022

`define WMC_LAST_MSB 15
`define WMC_LAST_LSB 8
`define WMC_RES_MSB 5
`define WMC_RES_LSB 4
`define WMC_CNT_MSB 3
`define WMC_CNT_LSB 0
`define WMC_DOUT1_BIT 1
`define WMC_DOUT2_BIT 0

`define WMC_RES_NONE 2'h0
`define WMC_RES_OK 2'h1
`define WMC_RES_FAIL 2'h2
`define WMC_RES_UNKNOWN 2'h3

`define WMC_REG_RESET 16'h0000
`define WMC_UV_READ 16'h0000

`endif

// ===== wmc_pkg.sv
// Types and helpers of the command port
package wmc_pkg;
    typedef enum logic {WMC_ST_IDLE, WMC_ST_WAIT} wmc_state_t;
    typedef logic [15:0] wmc_word_t;

    // High register carries the most significant half
    function automatic logic [31:0] wmc_join(input wmc_word_t hi,
                                             input wmc_word_t lo);
        return {hi, lo};
    endfunction
endpackage

// ===== wmc_if.sv
// Link between the register file and the command sequencer
`timescale 1ns/1ps
interface wmc_if;
    logic go;
    logic [15:0] code;
    logic [31:0] p1;
    logic [31:0] p2;
    logic busy;
    logic [15:0] cmd_stat;
    logic [15:0] out_stat;
    modport regs_mp (output go, code, p1, p2,
                     input busy, cmd_stat, out_stat);
    modport seq_mp (input go, code, p1, p2,
                    output busy, cmd_stat, out_stat);
endinterface

// ===== wmc_regs.sv
// Register file and read/write access of the command port
`timescale 1ns/1ps
`include "wmc_map.svh"
module wmc_regs import wmc_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_err,
    wmc_if.regs_mp cif
);
    wmc_word_t cmd_r, cmd_nxt, p1h_r, p1h_nxt, p1l_r, p1l_nxt;
    wmc_word_t p2h_r, p2h_nxt, p2l_r, p2l_nxt, rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt, err_r, err_nxt;

    always_comb begin
        cmd_nxt = cmd_r;
        p1h_nxt = p1h_r;
        p1l_nxt = p1l_r;
        p2h_nxt = p2h_r;
        p2l_nxt = p2l_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        err_nxt = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                `WMC_ADDR_CMD_CODE: cmd_nxt = reg_wdata;
                `WMC_ADDR_P1_HIGH: p1h_nxt = reg_wdata;
                `WMC_ADDR_P1_LOW: p1l_nxt = reg_wdata;
                `WMC_ADDR_P2_HIGH: p2h_nxt = reg_wdata;
                `WMC_ADDR_P2_LOW: p2l_nxt = reg_wdata;
                default: err_nxt = 1'b1;
            endcase
        end else if (reg_rd) begin
            rvalid_nxt = 1'b1;
            unique case (reg_addr)
                `WMC_ADDR_CMD_STATUS: rdata_nxt = cif.cmd_stat;
                `WMC_ADDR_OUT_STATUS: rdata_nxt = cif.out_stat;
                `WMC_ADDR_CH1_UV: rdata_nxt = `WMC_UV_READ;
                `WMC_ADDR_CMD_CODE: rdata_nxt = cmd_r;
                `WMC_ADDR_P1_HIGH: rdata_nxt = p1h_r;
                `WMC_ADDR_P1_LOW: rdata_nxt = p1l_r;
                `WMC_ADDR_P2_HIGH: rdata_nxt = p2h_r;
                `WMC_ADDR_P2_LOW: rdata_nxt = p2l_r;
                default: begin
                    rdata_nxt = `WMC_REG_RESET;
                    err_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cmd_r <= `WMC_REG_RESET;
            p1h_r <= `WMC_REG_RESET;
            p1l_r <= `WMC_REG_RESET;
            p2h_r <= `WMC_REG_RESET;
            p2l_r <= `WMC_REG_RESET;
            rdata_r <= `WMC_REG_RESET;
            rvalid_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            p1h_r <= p1h_nxt;
            p1l_r <= p1l_nxt;
            p2h_r <= p2h_nxt;
            p2l_r <= p2l_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            err_r <= err_nxt;
        end
    end

    // A code write while not busy starts a command; code zero requests nothing
    assign cif.go = reg_wr && reg_addr == `WMC_ADDR_CMD_CODE &&
                    reg_wdata != `WMC_CODE_NONE && !cif.busy;
    assign cif.code = reg_wdata;
    assign cif.p1 = wmc_join(p1h_r, p1l_r);
    assign cif.p2 = wmc_join(p2h_r, p2l_r);
    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign reg_err = err_r;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    a_zero_code_idle: assert property (
        reg_wr && reg_addr == `WMC_ADDR_CMD_CODE &&
        reg_wdata == `WMC_CODE_NONE |-> !cif.go)
        else $error("Code zero started a command");
    a_param_order: assert property (
        reg_wr && reg_addr == `WMC_ADDR_P2_HIGH |=>
        cif.p2[31:16] == $past(reg_wdata))
        else $error("Second parameter high half misplaced");
endmodule // wmc_regs

// ===== wmc_core_model.sv
// Behavioural weighing core that answers the action pulses
`timescale 1ns/1ps
module wmc_core_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic [4:0] act_req,
    input wire logic [7:0] wait_cycles,
    input wire logic ok_val,
    output logic core_done,
    output logic core_ok
);
    logic pend_r;
    logic [7:0] cnt_r;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pend_r <= 1'b0;
            cnt_r <= 8'h00;
            core_done <= 1'b0;
        end else begin
            core_done <= 1'b0;
            if (act_req != 5'h00) begin
                pend_r <= 1'b1;
                cnt_r <= wait_cycles;
            end else if (pend_r && cnt_r == 8'h00) begin
                core_done <= 1'b1;
                pend_r <= 1'b0;
            end else if (pend_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end

    // Result is only meaningful beside done; otherwise show the opposite
    assign core_ok = core_done ? ok_val : ~ok_val;
endmodule // wmc_core_model

// ===== tb.sv
// Self-checking testbench of the command port
`timescale 1ns/1ps
`include "wmc_map.svh"
module tb;
    import wmc_pkg::*;
    logic clock, reset, reg_wr, reg_rd, ok_val, core_done, core_ok;
    logic reg_rvalid, reg_err, dout1, dout2, cmd_busy;
    logic zero_req, tare_req, preset_tare_req;
    logic setpoint1_load, setpoint2_load, reboot_req;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [31:0] action_value;
    logic [7:0] core_wait, last_code;
    logic [1:0] last_res, exp_dout;
    logic [3:0] cnt;
    int num_errors, n_tests;

    wmc_cmd_port i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
        .core_done(core_done), .core_ok(core_ok), .zero_req(zero_req),
        .tare_req(tare_req), .preset_tare_req(preset_tare_req),
        .setpoint1_load(setpoint1_load), .setpoint2_load(setpoint2_load),
        .reboot_req(reboot_req), .action_value(action_value),
        .dout1(dout1), .dout2(dout2), .cmd_busy(cmd_busy));

    wmc_core_model i_core (.clock(clock), .reset(reset),
        .act_req({zero_req, tare_req, preset_tare_req, setpoint1_load,
                  setpoint2_load}),
        .wait_cycles(core_wait), .ok_val(ok_val),
        .core_done(core_done), .core_ok(core_ok));

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, d);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, exp, input string name);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        check("read valid", 32'h1, {31'h0, reg_rvalid});
        check(name, {16'h0, exp}, {16'h0, reg_rdata});
    endtask

    // One command: load param one, write code, follow it to completion
    task automatic cmd(input logic [15:0] c, input logic [31:0] p,
                       input logic ok, input logic [5:0] pv,
                       input logic [1:0] res);
        int k;
        wr(`WMC_ADDR_P1_HIGH, p[31:16]);
        wr(`WMC_ADDR_P1_LOW, p[15:0]);
        ok_val = ok;
        wr(`WMC_ADDR_CMD_CODE, c);
        check("pulses", {26'h0, pv}, {26'h0, zero_req, tare_req,
              preset_tare_req, setpoint1_load, setpoint2_load, reboot_req});
        check("busy", {31'h0, pv[5:1] != 5'h00}, {31'h0, cmd_busy});
        if (pv[3:1] != 3'h0) check("action value", p, action_value);
        wr(`WMC_ADDR_P1_LOW, ~p[15:0]);
        k = 0;
        while (cmd_busy !== 1'b0 && k < 50) begin
            @(posedge clock);
            #1;
            k++;
        end
        if (k == 50) check("busy timeout", 32'h0, 32'h1);
        if (pv[3:1] != 3'h0) check("held value", p, action_value);
        if (c != `WMC_CODE_NONE) begin
            last_code = c[7:0];
            last_res = res;
            cnt = cnt + 4'h1;
        end
        rd(`WMC_ADDR_CMD_STATUS, {last_code, 2'b00, last_res, cnt}, "status");
        if (c == `WMC_CODE_DOUT) exp_dout = p[1:0];
        check("dout pins", {30'h0, exp_dout}, {30'h0, dout1, dout2});
        rd(`WMC_ADDR_OUT_STATUS, {14'h0, exp_dout}, "out map");
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        #(40 * 20000);
        num_errors++;
        test_done();
    end

    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        ok_val = 1'b1;
        core_wait = 8'h00;
        last_code = 8'h00;
        last_res = 2'h0;
        exp_dout = 2'h0;
        cnt = 4'h0;
        repeat (8) @(posedge clock);
        #1;
        reset = 1'b0;
        check("idle outs", 32'h0, {29'h0, dout1, dout2, cmd_busy});
        rd(`WMC_ADDR_CMD_STATUS, 16'h0000, "status");
        rd(`WMC_ADDR_OUT_STATUS, 16'h0000, "out status");
        rd(`WMC_ADDR_CH1_UV, 16'h0000, "uv");
        wr(`WMC_ADDR_CMD_STATUS, 16'hffff);
        check("ro write err", 32'h1, {31'h0, reg_err});
        wr(16'h1234, 16'h5555);
        check("unmapped err", 32'h1, {31'h0, reg_err});
        wr(`WMC_ADDR_P2_HIGH, 16'habcd);
        wr(`WMC_ADDR_P2_LOW, 16'h0123);
        rd(`WMC_ADDR_P2_HIGH, 16'habcd, "p2 high");
        rd(`WMC_ADDR_P2_LOW, 16'h0123, "p2 low");
        cmd(`WMC_CODE_ZERO, 32'h0, 1'b1, 6'h20, `WMC_RES_OK);
        core_wait = 8'h05;
        cmd(`WMC_CODE_TARE, 32'h0, 1'b0, 6'h10, `WMC_RES_FAIL);
        cmd(`WMC_CODE_PTARE, 32'h0000_03e8, 1'b1, 6'h08, `WMC_RES_OK);
        // A code written while busy is stored but starts nothing
        core_wait = 8'h08;
        wr(`WMC_ADDR_CMD_CODE, `WMC_CODE_TARE);
        wr(`WMC_ADDR_CMD_CODE, `WMC_CODE_ZERO);
        check("busy drop", 32'h0, {31'h0, zero_req});
        rd(`WMC_ADDR_CMD_CODE, `WMC_CODE_ZERO, "code store");
        repeat (12) @(posedge clock);
        #1;
        check("busy end", 32'h0, {31'h0, cmd_busy});
        last_code = 8'h02;
        last_res = `WMC_RES_OK;
        cnt = cnt + 4'h1;
        rd(`WMC_ADDR_CMD_STATUS, {last_code, 2'b00, last_res, cnt}, "status");
        core_wait = 8'h00;
        cmd(`WMC_CODE_SP1, 32'h8000_1234, 1'b1, 6'h04, `WMC_RES_OK);
        cmd(`WMC_CODE_SP2, 32'h0001_0002, 1'b1, 6'h02, `WMC_RES_OK);
        cmd(`WMC_CODE_DOUT, 32'hffff_ffff, 1'b1, 6'h00, `WMC_RES_OK);
        rd(`WMC_ADDR_OUT_STATUS, 16'h0003, "out on");
        cmd(`WMC_CODE_DOUT, 32'h0, 1'b1, 6'h00, `WMC_RES_OK);
        rd(`WMC_ADDR_OUT_STATUS, 16'h0000, "out off");
        cmd(`WMC_CODE_REBOOT, 32'h0, 1'b1, 6'h01, `WMC_RES_OK);
        cmd(`WMC_CODE_NONE, 32'h0, 1'b1, 6'h00, `WMC_RES_NONE);
        cmd(16'h0055, 32'h0, 1'b1, 6'h00, `WMC_RES_UNKNOWN);
        for (int i = 0; i < 8; i++) begin
            cmd(`WMC_CODE_ZERO, 32'h0, 1'b1, 6'h20, `WMC_RES_OK);
        end
        test_done();
    end
endmodule // tb
